// *** logic/arh_appliance.sv ***
// Purpose: appliance-side recognition service: answers capability requests
// Assumes: bytes arrive already deframed by a uart on clk_sys
// Notes: replies start at once; answer_late flags a reply still being sent at the answer limit
`timescale 1ns/100ps
`include "arh_defines.svh"
module arh_appliance #(
  parameter int ANSWER_LIMIT_CYC = `ARH_ANSWER_LIMIT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // received bytes from the adapter
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  // bytes sent to the adapter
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  // capability settings of this appliance
  input wire logic [7:0] cfg_type,
  input wire logic [7:0] cfg_speed,
  input wire logic [7:0] cfg_props,
  input wire logic [23:0] cfg_maker,
  input wire logic [7:0] cfg_class_group,
  input wire logic [7:0] cfg_class_id,
  input wire logic [15:0] cfg_model,
  input wire logic cfg_numbering,
  // status
  output arh_pkg::arh_state_e state,
  output logic [7:0] note_result,
  output logic note_seen,
  output logic frame_drop,
  output logic answer_late,
  output logic cfg_bad
);
  import arh_pkg::*;

  arh_state_e state_q;
  arh_rx_e rx_q;
  logic [2:0] hcnt_q;
  logic [4:0] dcnt_q;
  logic [7:0] sum_q;
  logic ft_ok_q;
  logic [7:0] cmd_q;
  logic [7:0] fn_q;
  logic [15:0] dl_q;
  logic [7:0] pay0_q;
  logic frame_q;
  logic drop_q;
  logic [7:0] fr_q [`ARH_FRAME_MAX];
  logic [4:0] len_q;
  logic [4:0] idx_q;
  logic busy_q;
  logic [7:0] tx_byte_q;
  logic [26:0] timer_q;
  logic late_q;
  logic [7:0] note_q;
  logic seen_q;
  logic bad_q;

  // decoded actions on a good frame
  logic is_req;
  logic is_note;
  logic note_ok;
  logic load;
  logic acc_kind;
  assign is_req = frame_q && cmd_q == `ARH_CMD_CAP_REQ && dl_q == 16'h0000;
  assign is_note = frame_q && cmd_q == `ARH_CMD_NOTE && dl_q == `ARH_DL_NOTE;
  assign note_ok = pay0_q == `ARH_RES_OK || pay0_q == `ARH_RES_SPEED ||
                   pay0_q == `ARH_RES_PEER || pay0_q == `ARH_RES_OBJ;
  // busy transmitter refuses new work; adapter must not overlap frames
  assign load = !busy_q && (is_req || (is_note && state_q == ARH_WAIT_NOTE && note_ok));
  assign acc_kind = is_note;

  // receive parser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_q <= ARH_RX_HUNT;
      hcnt_q <= 3'h0;
      dcnt_q <= 5'h00;
      sum_q <= 8'h00;
      ft_ok_q <= 1'b0;
      cmd_q <= 8'h00;
      fn_q <= 8'h00;
      dl_q <= 16'h0000;
      pay0_q <= 8'h00;
      frame_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      frame_q <= 1'b0;
      drop_q <= 1'b0;
      if (rx_valid) begin
        unique case (rx_q)
          ARH_RX_HUNT: begin
            if (rx_byte == `ARH_STX) begin
              rx_q <= ARH_RX_HDR;
              hcnt_q <= 3'h0;
              sum_q <= 8'h00;
              ft_ok_q <= 1'b1;
            end
          end
          ARH_RX_HDR: begin
            sum_q <= sum_q + rx_byte;
            hcnt_q <= hcnt_q + 3'h1;
            unique case (hcnt_q)
              3'h0, 3'h1: ft_ok_q <= ft_ok_q && rx_byte == `ARH_FT_BYTE;
              3'h2: cmd_q <= rx_byte;
              3'h3: fn_q <= rx_byte;
              3'h4: dl_q[15:8] <= rx_byte;
              default: begin
                dl_q[7:0] <= rx_byte;
                dcnt_q <= 5'h00;
                if ({dl_q[15:8], rx_byte} == 16'h0000) begin
                  rx_q <= ARH_RX_CHK;
                end else if ({dl_q[15:8], rx_byte} > `ARH_DL_MAX) begin
                  rx_q <= ARH_RX_HUNT;
                  drop_q <= 1'b1;
                end else begin
                  rx_q <= ARH_RX_DATA;
                end
              end
            endcase
          end
          ARH_RX_DATA: begin
            sum_q <= sum_q + rx_byte;
            if (dcnt_q == 5'h00) begin
              pay0_q <= rx_byte;
            end
            dcnt_q <= dcnt_q + 5'h01;
            if (dcnt_q + 5'h01 == dl_q[4:0]) begin
              rx_q <= ARH_RX_CHK;
            end
          end
          ARH_RX_CHK: begin
            rx_q <= ARH_RX_HUNT;
            // check byte plus sum of header and payload bytes after STX wraps to zero
            if (ft_ok_q && 8'(sum_q + rx_byte) == 8'h00) begin
              frame_q <= 1'b1;
            end else begin
              drop_q <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // answer frame image
  logic [7:0] fr_d [`ARH_FRAME_MAX];
  logic [4:0] len_d;
  logic [7:0] fn_echo;
  logic [7:0] speed_ok;
  logic props_bad;
  logic peer;
  always_comb begin
    logic [7:0] s;
    s = 8'h00;
    fn_echo = cfg_numbering ? fn_q : 8'h00;
    // reserved speed code never goes on the wire
    speed_ok = cfg_speed > `ARH_SPEED_MAX ? 8'h00 : cfg_speed;
    props_bad = cfg_props[7:6] != `ARH_SEQ_POLL && cfg_props[7:6] != `ARH_SEQ_BIDIR;
    peer = cfg_type[`ARH_PEER_BIT];
    for (int i = 0; i < `ARH_FRAME_MAX; i++) begin
      fr_d[i] = 8'h00;
    end
    fr_d[0] = `ARH_STX;
    fr_d[1] = `ARH_FT_BYTE;
    fr_d[2] = `ARH_FT_BYTE;
    fr_d[4] = fn_echo;
    if (acc_kind) begin
      fr_d[3] = `ARH_CMD_ACCEPT;
      len_d = `ARH_LEN_ACC;
    end else begin
      fr_d[3] = `ARH_CMD_CAP_RPL;
      fr_d[6] = peer ? `ARH_DL_PEER : `ARH_DL_OBJ;
      fr_d[7] = cfg_type & `ARH_TYPE_MASK;
      fr_d[8] = speed_ok;
      if (peer) begin
        fr_d[9] = cfg_props & `ARH_PROPS_MASK;
        fr_d[10] = cfg_maker[23:16];
        fr_d[11] = cfg_maker[15:8];
        fr_d[12] = cfg_maker[7:0];
        fr_d[13] = cfg_class_group;
        fr_d[14] = cfg_class_id;
        fr_d[15] = cfg_model[15:8];
        fr_d[16] = cfg_model[7:0];
      end
      len_d = peer ? `ARH_LEN_PEER : `ARH_LEN_OBJ;
    end
    for (int i = 1; i < `ARH_FRAME_MAX; i++) begin
      if (5'(i) < len_d - 5'h01) begin
        s = s + fr_d[i];
      end
    end
    fr_d[len_d - 5'h01] = 8'h00 - s;
  end

  // transmitter: one byte per accepted handshake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `ARH_FRAME_MAX; i++) begin
        fr_q[i] <= 8'h00;
      end
      len_q <= 5'h00;
      idx_q <= 5'h00;
      busy_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else if (load) begin
      fr_q <= fr_d;
      len_q <= len_d;
      idx_q <= 5'h00;
      busy_q <= 1'b1;
      tx_byte_q <= fr_d[0];
    end else if (busy_q && tx_ready) begin
      idx_q <= idx_q + 5'h01;
      // no read past the image once the last byte is gone
      if (idx_q + 5'h01 == len_q) begin
        busy_q <= 1'b0;
        tx_byte_q <= 8'h00;
      end else begin
        tx_byte_q <= fr_q[idx_q + 5'h01];
      end
    end
  end

  // handshake state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ARH_UNRECOGNIZED;
      note_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b0;
      if (is_req && !busy_q) begin
        state_q <= ARH_WAIT_NOTE;
      end else if (is_note && state_q == ARH_WAIT_NOTE && !busy_q) begin
        note_q <= pay0_q;
        seen_q <= 1'b1;
        if (note_ok) begin
          state_q <= ARH_UNCONFIRMED;
        end else if (pay0_q == `ARH_RES_NG) begin
          state_q <= ARH_UNRECOGNIZED;
        end
      end
      // other codes leave the state untouched
    end
  end

  // watchdog on our own answer time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timer_q <= 27'h0000000;
      late_q <= 1'b0;
    end else begin
      late_q <= 1'b0;
      if (load) begin
        timer_q <= 27'h0000001;
      end else if (busy_q && timer_q != 27'h0000000) begin
        timer_q <= timer_q + 27'h0000001;
        if (timer_q == 27'(ANSWER_LIMIT_CYC)) begin
          late_q <= 1'b1;
          timer_q <= 27'h0000000;
        end
      end else if (!busy_q) begin
        timer_q <= 27'h0000000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bad_q <= 1'b0;
    end else begin
      bad_q <= cfg_speed > `ARH_SPEED_MAX || (peer && props_bad);
    end
  end

  assign tx_byte = tx_byte_q;
  assign tx_valid = busy_q;
  assign state = state_q;
  assign note_result = note_q;
  assign note_seen = seen_q;
  assign frame_drop = drop_q;
  assign answer_late = late_q;
  assign cfg_bad = bad_q;
endmodule : arh_appliance

// *** logic/arh_defines.svh ***
// Purpose: constants for the appliance end of the recognition handshake
// Assumes: byte-wide link, 250 MHz system clock
// Notes: included by the controller only, not by the package
`ifndef ARH_DEFINES_SVH
`define ARH_DEFINES_SVH
`define ARH_STX 8'h02
`define ARH_FT_BYTE 8'hFF
`define ARH_CMD_CAP_REQ 8'h00
`define ARH_CMD_CAP_RPL 8'h80
`define ARH_CMD_NOTE 8'h01
`define ARH_CMD_ACCEPT 8'h81
`define ARH_RES_OK 8'h00
`define ARH_RES_NG 8'h01
`define ARH_RES_SPEED 8'h02
`define ARH_RES_PEER 8'h11
`define ARH_RES_OBJ 8'h12
`define ARH_TYPE_MASK 8'h03
`define ARH_PEER_BIT 0
`define ARH_SPEED_MAX 8'h06
`define ARH_PROPS_MASK 8'hF8
`define ARH_SEQ_POLL 2'h1
`define ARH_SEQ_BIDIR 2'h3
`define ARH_DL_MAX 16'h0010
`define ARH_DL_OBJ 8'h02
`define ARH_DL_PEER 8'h0A
`define ARH_DL_NOTE 16'h0001
`define ARH_LEN_OBJ 5'h0A
`define ARH_LEN_PEER 5'h12
`define ARH_LEN_ACC 5'h08
`define ARH_FRAME_MAX 18
`define ARH_ANSWER_LIMIT_MS 300
`define ARH_CLK_MHZ 250
`define ARH_ANSWER_LIMIT_CYC (`ARH_ANSWER_LIMIT_MS * 1000 * `ARH_CLK_MHZ)
`endif

// *** logic/arh_pkg.sv ***
// Purpose: types for the appliance end of the recognition handshake
// Assumes: arh_defines.svh holds the numbers
// Notes: one-hot state codes
package arh_pkg;
  typedef enum logic [2:0] {
    ARH_UNRECOGNIZED = 3'h1,
    ARH_WAIT_NOTE = 3'h2,
    ARH_UNCONFIRMED = 3'h4
  } arh_state_e;
  typedef enum logic [3:0] {
    ARH_RX_HUNT = 4'h1,
    ARH_RX_HDR = 4'h2,
    ARH_RX_DATA = 4'h4,
    ARH_RX_CHK = 4'h8
  } arh_rx_e;
endpackage : arh_pkg

// *** dv/arh_appliance_chk.sv ***
// Purpose: port assertions for arh_appliance
// Assumes: one clock domain
// Notes: byte index counts taken bytes in a frame
`timescale 1ns/100ps
module arh_chk (
  // clock and reset
  input logic clk_sys,
  input logic nrst,
  // link out
  input logic [7:0] tx_byte,
  input logic tx_valid,
  input logic tx_ready,
  // settings and status
  input logic [7:0] cfg_type,
  input arh_pkg::arh_state_e state,
  input logic [7:0] note_result,
  input logic note_seen
);
  import arh_pkg::*;
  logic [4:0] idx_q;
  logic [7:0] cmd_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) idx_q <= 5'h00;
    else if (!tx_valid) idx_q <= 5'h00;
    else if (tx_ready) idx_q <= idx_q + 5'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cmd_q <= 8'h00;
    else if (tx_valid && tx_ready && idx_q == 5'h03) cmd_q <= tx_byte;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_accepted;
    note_seen && state == ARH_UNCONFIRMED;
  endsequence
  a_start_byte: assert property (tx_valid && idx_q == 5'h00 |-> tx_byte == 8'h02)
    else $error("frame start wrong");
  a_reply_cmd: assert property (tx_valid && idx_q == 5'h03 |-> tx_byte inside {8'h80, 8'h81})
    else $error("reply command wrong");
  a_length_code: assert property (tx_valid && idx_q == 5'h06 && cmd_q == 8'h80 |->
    tx_byte == (cfg_type[0] ? 8'h0A : 8'h02)) else $error("reply length wrong");
  a_type_clean: assert property (tx_valid && idx_q == 5'h07 && cmd_q == 8'h80 |->
    tx_byte == {6'h00, cfg_type[1:0]}) else $error("type byte wrong");
  a_speed_legal: assert property (tx_valid && idx_q == 5'h08 && cmd_q == 8'h80 |->
    tx_byte <= 8'h06) else $error("speed code reserved");
  a_props_clean: assert property (tx_valid && idx_q == 5'h09 && cmd_q == 8'h80 && cfg_type[0]
    |-> tx_byte[2:0] == 3'h0) else $error("props low bits set");
  a_accept_len: assert property (tx_valid && idx_q == 5'h06 && cmd_q == 8'h81 |->
    tx_byte == 8'h00) else $error("accept length wrong");
  a_byte_hold: assert property (s_stall |=> tx_valid && $stable(tx_byte))
    else $error("byte changed while stalled");
  a_accept_sent: assert property (s_accepted |-> tx_valid ##1 tx_valid)
    else $error("no accept after support");
  a_refuse_idle: assert property (note_seen && note_result == 8'h01 |->
    state == ARH_UNRECOGNIZED && !tx_valid) else $error("unsupported not idle");
endmodule : arh_chk
bind arh_appliance arh_chk i_chk (.clk_sys, .nrst, .tx_byte, .tx_valid, .tx_ready,
  .cfg_type, .state, .note_result, .note_seen);

// *** dv/arh_adapter.sv ***
// Purpose: adapter-side model of the recognition handshake
// Assumes: bytes already deframed, same clock
// Notes: the bench calls send and reads got
`timescale 1ns/100ps
module arh_adapter (
  // clock
  input logic clk_sys,
  // bytes to the appliance
  output logic [7:0] rx_byte,
  output logic rx_valid,
  // bytes from the appliance
  input logic [7:0] tx_byte,
  input logic tx_valid,
  output logic tx_ready
);
  logic slow_q = 1'b0;
  logic hold_q = 1'b0;
  logic [7:0] cap_q = 8'h00;
  logic [7:0] got[$];
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready && got.size() == 7 && got[3] == 8'h80) cap_q <= tx_byte;
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    tx_ready <= #1 !hold_q && !(slow_q && tx_ready);
  end
  task automatic send(input logic [7:0] cmd, fn, dl, res, bad);
    logic [7:0] b[$];
    logic [7:0] s;
    b = '{8'hFF, 8'hFF, cmd, fn, 8'h00, dl};
    if (dl != 8'h00) b.push_back(res);
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    b.push_back((8'h00 - s) ^ bad);
    b.push_front(8'h02);
    got.delete();
    @(posedge clk_sys);
    foreach (b[i]) begin
      rx_byte <= #1 b[i];
      rx_valid <= #1 1'b1;
      @(posedge clk_sys);
    end
    // released line shows no stale byte
    rx_byte <= #1 ~b[b.size() - 1];
    rx_valid <= #1 1'b0;
  endtask : send
endmodule : arh_adapter

// *** dv/arh_appliance_tb.sv ***
// Purpose: bench for arh_appliance
// Assumes: adapter model on the link
// Notes: answer limit cut to LIM cycles
`timescale 1ns/100ps
module arh_appliance_tb;
  import arh_pkg::*;
  localparam int LIM = 50;
  logic clk_sys, nrst, rx_valid, tx_valid, tx_ready, cfg_numbering;
  logic note_seen, frame_drop, answer_late, cfg_bad;
  logic [7:0] rx_byte, tx_byte, cfg_type, cfg_speed, cfg_props, cfg_class_group, cfg_class_id;
  logic [7:0] note_result;
  logic [23:0] cfg_maker;
  logic [15:0] cfg_model;
  arh_state_e state;
  int n_fail = 0, checks_done = 0, drops = 0, lates = 0;
  arh_appliance #(.ANSWER_LIMIT_CYC(LIM)) i_dut (.clk_sys, .nrst, .rx_byte, .rx_valid,
    .tx_byte, .tx_valid, .tx_ready, .cfg_type, .cfg_speed, .cfg_props, .cfg_maker,
    .cfg_class_group, .cfg_class_id, .cfg_model, .cfg_numbering, .state, .note_result,
    .note_seen, .frame_drop, .answer_late, .cfg_bad);
  arh_adapter i_adp (.clk_sys, .rx_byte, .rx_valid, .tx_byte, .tx_valid, .tx_ready);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    drops += int'(frame_drop === 1'b1);
    lates += int'(answer_late === 1'b1);
  end
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : cmp
  task automatic cmp_frame(input logic [7:0] e[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (e[i]) if (i > 0) s = s + e[i];
    e.push_back(8'h00 - s);
    cmp("frame size", e.size(), i_adp.got.size());
    foreach (e[i]) cmp("frame byte", e[i], i_adp.got[i]);
  endtask : cmp_frame
  task automatic wait_reply();
    int k;
    k = 0;
    while (tx_valid !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    while (tx_valid !== 1'b0 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    cmp("reply done", 1'b0, tx_valid);
  endtask : wait_reply
  task automatic xfer(input logic [7:0] cmd, fn, dl, res, bad);
    i_adp.send(cmd, fn, dl, res, bad);
    wait_reply();
  endtask : xfer
  task automatic t_object();
    xfer(8'h00, 8'h05, 8'h00, 8'h00, 8'h00);
    cmp_frame('{8'h02, 8'hFF, 8'hFF, 8'h80, 8'h05, 8'h00, 8'h02, 8'h02, 8'h03});
    cmp("latched type", 8'h02, i_adp.cap_q);
    xfer(8'h01, 8'h06, 8'h01, 8'h03, 8'h00);
    cmp("state", ARH_WAIT_NOTE, state);
    xfer(8'h01, 8'h07, 8'h01, 8'h00, 8'h00);
    cmp_frame('{8'h02, 8'hFF, 8'hFF, 8'h81, 8'h07, 8'h00, 8'h00});
    cmp("state", ARH_UNCONFIRMED, state);
  endtask : t_object
  task automatic t_codes();
    logic [7:0] codes[4] = '{8'h00, 8'h02, 8'h11, 8'h12};
    foreach (codes[i]) begin
      xfer(8'h00, 8'h10 + 8'(i), 8'h00, 8'h00, 8'h00);
      xfer(8'h01, 8'hFF, 8'h01, codes[i], 8'h00);
      cmp("state", ARH_UNCONFIRMED, state);
      cmp("result", codes[i], note_result);
    end
  endtask : t_codes
  task automatic t_peer();
    cfg_type = 8'h01;
    cfg_numbering = 1'b0;
    i_adp.slow_q = 1'b1;
    xfer(8'h00, 8'h22, 8'h00, 8'h00, 8'h00);
    cmp_frame('{8'h02, 8'hFF, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h0A, 8'h01, 8'h04, 8'h58,
      8'h12, 8'h34, 8'h56, 8'h0A, 8'h0B, 8'hCD, 8'hEF});
    i_adp.slow_q = 1'b0;
    xfer(8'h01, 8'h23, 8'h01, 8'h01, 8'h00);
    cmp("state", ARH_UNRECOGNIZED, state);
    cmp("silent", 0, i_adp.got.size());
  endtask : t_peer
  task automatic t_faults();
    xfer(8'h00, 8'h30, 8'h00, 8'h00, 8'h01);
    cmp("dropped", 1, drops);
    xfer(8'h05, 8'h31, 8'h00, 8'h00, 8'h00);
    cmp("ignored", 0, i_adp.got.size());
    cmp("state", ARH_UNRECOGNIZED, state);
    cmp("cfg bad", 1'b0, cfg_bad);
    cfg_speed = 8'h07;
    i_adp.hold_q = 1'b1;
    i_adp.send(8'h00, 8'h32, 8'h00, 8'h00, 8'h00);
    repeat (LIM + 10) @(posedge clk_sys);
    cmp("late", 1, lates);
    i_adp.hold_q = 1'b0;
    wait_reply();
    cmp("speed", 8'h00, i_adp.got[8]);
    cmp("cfg bad", 1'b1, cfg_bad);
    cfg_speed = 8'h04;
    cfg_props = 8'h9F;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp("cfg bad", 1'b1, cfg_bad);
    cfg_props = 8'h5F;
  endtask : t_faults
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    cfg_type = 8'h02;
    cfg_speed = 8'h03;
    cfg_props = 8'h5F;
    cfg_maker = 24'h123456;
    cfg_class_group = 8'h0A;
    cfg_class_id = 8'h0B;
    cfg_model = 16'hCDEF;
    cfg_numbering = 1'b1;
    repeat (20) @(posedge clk_sys);
    nrst <= #1 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    t_object();
    t_codes();
    cfg_speed = 8'h04;
    t_peer();
    t_faults();
    report_and_stop();
  end
endmodule : arh_appliance_tb
